// *** front_end_pkg.sv ***
// constants and types shared by the black loop and segment correction block
// How it works
// - weight code 00..11 selects 1x,2x,4x,8x
// - black error (64 minus sample) times weight enters loop sum
// - clamp count sets pixels summed per update
// - loop config register read/write, resets 2Ah
// - three correction registers read-only, reset zero
// - first offset signed, used in 4x segment
// - second offset signed, used in 2x segment
// - calibration end loads all three offsets
// - 8x segment output equals raw sample
// - 4x segment: raw times two plus first
// - 2x segment: raw times four plus twice second
// - 1x segment: raw times eight plus four third
// - trigger starts calibration, self clears, 760 clocks
// - loop drives black pixel output toward 64
// - black accumulator is nine bits wide
`default_nettype none
package front_end_pkg;
    localparam logic [7:0] ADDR_BLACK_LOOP   = 8'h0D;
    localparam logic [7:0] ADDR_CORR_FIRST   = 8'h0E;
    localparam logic [7:0] ADDR_CORR_SECOND  = 8'h0F;
    localparam logic [7:0] ADDR_CORR_THIRD   = 8'h10;
    localparam logic [7:0] BLACK_LOOP_RESET  = 8'h2A;
    localparam logic [7:0] CORR_RESET        = 8'h00;
    localparam int         WEIGHT_MSB        = 7;
    localparam int         WEIGHT_LSB        = 6;
    localparam int         CLAMP_MSB         = 5;
    localparam int         CLAMP_LSB         = 0;
    localparam int         RAW_W             = 10;
    localparam int         OUT_W             = 13;
    localparam int         CALC_W            = 15;
    localparam int         ACC_W             = 9;
    localparam int         SUM_W             = 22;
    localparam int         UPDATE_SHIFT      = 8;
    localparam logic [9:0] BLACK_TARGET      = 10'h040;
    localparam logic [8:0] BLACK_ACC_RESET   = 9'h100;
    localparam logic [8:0] BLACK_ACC_MAX     = 9'h1FF;
    localparam logic [12:0] OUT_MAX          = 13'h1FFF;
    localparam logic [9:0] CAL_CLOCKS        = 10'h2F8;

    typedef enum logic [1:0] {
        SEG_1X = 2'h0,
        SEG_2X = 2'h1,
        SEG_4X = 2'h2,
        SEG_8X = 2'h3
    } segment_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'h1,
        CAL_RUN  = 2'h2
    } cal_state_t;
endpackage
`default_nettype wire

// *** stream_if.sv ***
// valid/ready word channel between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface stream_if;
    logic                               valid;
    logic                               ready;
    logic [front_end_pkg::OUT_W-1:0]    data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** two_entry_buffer.sv ***
// two-entry buffer for corrected samples
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer (
    input  wire logic   clk,
    input  wire logic   srst,
    stream_if.sink      fill,
    stream_if.source    drain
);
    import front_end_pkg::*;

    logic [OUT_W-1:0] slot [2];
    logic [OUT_W-1:0] next_slot [2];
    logic             wr_ptr;
    logic             next_wr_ptr;
    logic             rd_ptr;
    logic             next_rd_ptr;
    logic [1:0]       count;
    logic [1:0]       next_count;
    logic             push;
    logic             pop;

    // handshakes: honest full and empty
    assign fill.ready  = (count != 2'h2);
    assign drain.valid = (count != 2'h0);
    assign drain.data  = slot[rd_ptr];
    assign push        = fill.valid & fill.ready;
    assign pop         = drain.valid & drain.ready;

    // next pointers, count and storage
    always_comb begin
        next_wr_ptr = wr_ptr ^ push;
        next_rd_ptr = rd_ptr ^ pop;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
        for (int i = 0; i < 2; i++) begin
            next_slot[i] = slot[i];
        end
        if (push) begin
            next_slot[wr_ptr] = fill.data;
        end
    end

    // register state
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr  <= 1'b0;
            rd_ptr  <= 1'b0;
            count   <= 2'h0;
            slot[0] <= '0;
            slot[1] <= '0;
        end else begin
            wr_ptr  <= next_wr_ptr;
            rd_ptr  <= next_rd_ptr;
            count   <= next_count;
            slot[0] <= next_slot[0];
            slot[1] <= next_slot[1];
        end
    end
endmodule
`default_nettype wire

// *** cal_sequencer.sv ***
// gain calibration sequencer: timed run, load pulse at the end
`timescale 1ns/1ps
`default_nettype none
module cal_sequencer (
    input  wire logic   clk,
    input  wire logic   srst,
    input  wire logic   cal_request,
    output logic        cal_busy,
    output logic        cal_load
);
    import front_end_pkg::*;

    cal_state_t state;
    cal_state_t next_state;
    logic [9:0] count;
    logic [9:0] next_count;
    logic       next_load;

    // request starts at once, requests during a run are ignored
    always_comb begin
        next_state = state;
        next_count = count;
        next_load  = 1'b0;
        case (state)
            CAL_IDLE: begin
                if (cal_request) begin
                    next_state = CAL_RUN;
                    next_count = 10'h000;
                end
            end
            CAL_RUN: begin
                next_count = count + 10'h001;
                if (count == CAL_CLOCKS - 10'h001) begin
                    next_state = CAL_IDLE;
                    next_load  = 1'b1;
                end
            end
            default: begin
                next_state = CAL_IDLE;
            end
        endcase
    end

    // register state
    always_ff @(posedge clk) begin
        if (srst) begin
            state    <= CAL_IDLE;
            count    <= 10'h000;
            cal_load <= 1'b0;
        end else begin
            state    <= next_state;
            count    <= next_count;
            cal_load <= next_load;
        end
    end

    assign cal_busy = (state == CAL_RUN);
endmodule
`default_nettype wire

// *** black_loop_and_gain_offset.sv ***
// black level loop and gain segment correction, with register port
`timescale 1ns/1ps
`default_nettype none
module black_loop_and_gain_offset (
    input  wire logic                               clk,
    input  wire logic                               srst,

    // register port
    input  wire logic [7:0]                         reg_addr,
    input  wire logic                               reg_write,
    input  wire logic [7:0]                         reg_wdata,
    input  wire logic                               reg_read,
    output logic [7:0]                              reg_rdata,

    // calibration
    input  wire logic                               cal_request,
    output logic                                    cal_busy,
    input  wire logic [7:0]                         measured_offset_first,
    input  wire logic [7:0]                         measured_offset_second,
    input  wire logic [7:0]                         measured_offset_third,

    // converter samples
    input  wire logic                               sample_valid,
    output logic                                    sample_ready,
    input  wire logic [front_end_pkg::RAW_W-1:0]    sample_raw,
    input  wire front_end_pkg::segment_t            sample_segment,
    input  wire logic                               black_pixel,

    // black level offset to the sampler
    output logic [front_end_pkg::ACC_W-1:0]         black_level,

    // corrected output stream
    output logic                                    out_valid,
    input  wire logic                               out_ready,
    output logic [front_end_pkg::OUT_W-1:0]         out_data
);
    import front_end_pkg::*;

    // registers
    logic [7:0]              loop_cfg;
    logic [7:0]              next_loop_cfg;

    logic [7:0]              correction_offset_first;
    logic [7:0]              next_correction_offset_first;

    logic [7:0]              correction_offset_second;
    logic [7:0]              next_correction_offset_second;

    logic [7:0]              correction_offset_third;
    logic [7:0]              next_correction_offset_third;

    logic [7:0]              next_reg_rdata;

    // black loop state
    logic [ACC_W-1:0]        acc;
    logic [ACC_W-1:0]        next_acc;

    logic signed [SUM_W-1:0] loop_sum;
    logic signed [SUM_W-1:0] next_loop_sum;

    logic [5:0]              pixel_count;
    logic [5:0]              next_pixel_count;

    // datapath helpers
    logic                    cal_load;
    logic                    accepted;

    // configuration fields
    logic [1:0]              weight_shift;
    logic [5:0]              clamp_len;

    // correction operands
    logic signed [CALC_W-1:0] raw_ext;
    logic signed [CALC_W-1:0] off_first;
    logic signed [CALC_W-1:0] off_second;
    logic signed [CALC_W-1:0] off_third;
    logic signed [CALC_W-1:0] corrected;
    logic [OUT_W-1:0]        corrected_clamped;

    // black loop arithmetic
    logic signed [SUM_W-1:0] black_err;
    logic signed [SUM_W-1:0] weighted;
    logic signed [SUM_W-1:0] period_total;
    logic signed [SUM_W-1:0] acc_wide;

    // words into and out of the buffer
    stream_if to_buffer ();
    stream_if from_buffer ();

    // calibration sequencer
    // samples during a run are dropped
    cal_sequencer u_cal (
        .clk         (clk),
        .srst        (srst),
        .cal_request (cal_request),
        .cal_busy    (cal_busy),
        .cal_load    (cal_load)
    );

    // output buffer, stall reaches the converter side
    two_entry_buffer u_buf (
        .clk   (clk),
        .srst  (srst),
        .fill  (to_buffer.sink),
        .drain (from_buffer.source)
    );

    // stream handshakes; samples during calibration are dropped
    assign sample_ready      = to_buffer.ready;
    assign accepted          = sample_valid & sample_ready;

    // buffer input side
    assign to_buffer.valid   = sample_valid & ~cal_busy;
    assign to_buffer.data    = corrected_clamped;

    // buffer output side
    assign out_valid         = from_buffer.valid;
    assign out_data          = from_buffer.data;
    assign from_buffer.ready = out_ready;

    // configuration fields
    assign weight_shift = loop_cfg[WEIGHT_MSB:WEIGHT_LSB];
    assign clamp_len    = loop_cfg[CLAMP_MSB:CLAMP_LSB];

    // sampler offset
    assign black_level  = acc;

    // zero-extended raw code and sign-extended offsets for segment correction
    always_comb begin
        raw_ext    = $signed({{(CALC_W-RAW_W){1'b0}}, sample_raw});

        off_first  = $signed({{(CALC_W-8){correction_offset_first[7]}}, correction_offset_first});
        off_second = $signed({{(CALC_W-8){correction_offset_second[7]}}, correction_offset_second});
        off_third  = $signed({{(CALC_W-8){correction_offset_third[7]}}, correction_offset_third});
    end

    // segment correction for a continuous 13-bit output
    always_comb begin
        case (sample_segment)
            // 8x segment
            SEG_8X: begin
                corrected = raw_ext;
            end

            // 4x segment
            SEG_4X: begin
                corrected = (raw_ext <<< 1) + off_first;
            end

            // 2x segment
            SEG_2X: begin
                corrected = (raw_ext <<< 2) + (off_second <<< 1);
            end

            // 1x segment
            SEG_1X: begin
                corrected = (raw_ext <<< 3) + (off_third <<< 2);
            end

            default: begin
                corrected = raw_ext;
            end
        endcase
    end

    // saturate to the 13-bit output range
    always_comb begin
        if (corrected < 0) begin
            corrected_clamped = '0;
        end else if (corrected > $signed({2'b00, OUT_MAX})) begin
            // clip to the top code
            corrected_clamped = OUT_MAX;
        end else begin
            corrected_clamped = corrected[OUT_W-1:0];
        end
    end

    // weighted black pixel error toward the target code
    always_comb begin
        black_err = $signed({{(SUM_W-RAW_W){1'b0}}, BLACK_TARGET})
                  - $signed({{(SUM_W-RAW_W){1'b0}}, sample_raw});

        weighted  = black_err <<< weight_shift;

        period_total = loop_sum + weighted;
        acc_wide  = $signed({{(SUM_W-ACC_W){1'b0}}, acc}) + (period_total >>> UPDATE_SHIFT);
    end

    // black loop accumulation and update
    // each update adds sum >>> 8 to the accumulator
    always_comb begin
        next_acc         = acc;
        next_loop_sum    = loop_sum;
        next_pixel_count = pixel_count;

        if (accepted && black_pixel && !cal_busy && clamp_len != 6'h00) begin
            if (pixel_count + 6'h01 >= clamp_len) begin
                // one update, then a fresh period
                if (acc_wide < 0) begin
                    next_acc = '0;
                end else if (acc_wide > $signed({{(SUM_W-ACC_W){1'b0}}, BLACK_ACC_MAX})) begin
                    next_acc = BLACK_ACC_MAX;
                end else begin
                    next_acc = acc_wide[ACC_W-1:0];
                end

                next_loop_sum    = '0;
                next_pixel_count = 6'h00;
            end else begin
                // still inside the period
                next_loop_sum    = period_total;
                next_pixel_count = pixel_count + 6'h01;
            end
        end
    end

    // register black loop state
    // sum clears each period
    always_ff @(posedge clk) begin
        if (srst) begin
            acc         <= BLACK_ACC_RESET;

            loop_sum    <= '0;
            pixel_count <= 6'h00;
        end else begin
            acc         <= next_acc;

            loop_sum    <= next_loop_sum;
            pixel_count <= next_pixel_count;
        end
    end

    // register writes; correction registers ignore writes
    always_comb begin
        next_loop_cfg                 = loop_cfg;
        next_correction_offset_first  = correction_offset_first;
        next_correction_offset_second = correction_offset_second;
        next_correction_offset_third  = correction_offset_third;

        if (reg_write && reg_addr == ADDR_BLACK_LOOP) begin
            next_loop_cfg = reg_wdata;
        end

        // offsets load only at calibration end
        if (cal_load) begin
            next_correction_offset_first  = measured_offset_first;
            next_correction_offset_second = measured_offset_second;
            next_correction_offset_third  = measured_offset_third;
        end
    end

    // register read mux, unmapped addresses read zero
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_read) begin
            case (reg_addr)
                ADDR_BLACK_LOOP: begin
                    next_reg_rdata = loop_cfg;
                end

                ADDR_CORR_FIRST: begin
                    next_reg_rdata = correction_offset_first;
                end

                ADDR_CORR_SECOND: begin
                    next_reg_rdata = correction_offset_second;
                end

                ADDR_CORR_THIRD: begin
                    next_reg_rdata = correction_offset_third;
                end

                default: begin
                    next_reg_rdata = 8'h00;
                end
            endcase
        end
    end

    // register file state
    // offsets reset to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            loop_cfg                 <= BLACK_LOOP_RESET;

            correction_offset_first  <= CORR_RESET;
            correction_offset_second <= CORR_RESET;
            correction_offset_third  <= CORR_RESET;

            reg_rdata                <= 8'h00;
        end else begin
            loop_cfg                 <= next_loop_cfg;

            correction_offset_first  <= next_correction_offset_first;
            correction_offset_second <= next_correction_offset_second;
            correction_offset_third  <= next_correction_offset_third;

            reg_rdata                <= next_reg_rdata;
        end
    end
endmodule
`default_nettype wire

// *** black_loop_and_gain_offset_properties.sv ***
// port assertions for the black loop and segment correction block
`timescale 1ns/1ps
`default_nettype none
module black_loop_and_gain_offset_properties
    import front_end_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    srst,
    input wire logic [7:0]              reg_addr,
    input wire logic                    reg_write,
    input wire logic [7:0]              reg_wdata,
    input wire logic                    reg_read,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    cal_request,
    input wire logic                    cal_busy,
    input wire logic [7:0]              measured_offset_first,
    input wire logic [7:0]              measured_offset_second,
    input wire logic [7:0]              measured_offset_third,
    input wire logic                    sample_valid,
    input wire logic                    sample_ready,
    input wire logic [9:0]              sample_raw,
    input wire front_end_pkg::segment_t sample_segment,
    input wire logic                    black_pixel,
    input wire logic [8:0]              black_level,
    input wire logic                    out_valid,
    input wire logic                    out_ready,
    input wire logic [12:0]             out_data
);
    logic [10:0] busy_len;

    // length of the current calibration run
    always_ff @(posedge clk) begin
        if (srst || !cal_busy) begin
            busy_len <= 11'h000;
        end else begin
            busy_len <= busy_len + 11'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // calibration steps and sample acceptance
    sequence cal_start;
        !cal_busy && cal_request;
    endsequence
    sequence cal_end_read;
        $fell(cal_busy) ##[1:3] (reg_read && reg_addr == ADDR_CORR_FIRST);
    endsequence
    sequence sample_take;
        sample_valid && sample_ready && !cal_busy;
    endsequence

    a_cal_starts_now: assert property (cal_start |=> cal_busy)
        else $error("calibration did not start");
    a_cal_run_length: assert property ($fell(cal_busy) |-> busy_len == 11'h2F8)
        else $error("calibration run length wrong");
    a_cal_no_overrun: assert property (busy_len <= 11'h2F8)
        else $error("calibration overran");
    a_offset_loaded: assert property (cal_end_read |=> reg_rdata == measured_offset_first)
        else $error("offset not loaded at calibration end");
    a_rdata_stands: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (reg_read && (reg_addr < 8'h0D || reg_addr > 8'h10) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_level_frozen: assert property (cal_busy |=> $stable(black_level))
        else $error("black level moved in calibration");
    a_level_only_black: assert property (!(sample_valid && sample_ready && !cal_busy && black_pixel)
        |=> $stable(black_level))
        else $error("black level moved without black pixel");
    a_pass_through: assert property (sample_take and sample_segment == SEG_8X && !out_valid
        |=> out_valid && out_data == $past(sample_raw))
        else $error("8x sample not passed through");
    a_out_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output word dropped under stall");
    a_ready_empty: assert property (!out_valid |-> sample_ready)
        else $error("empty buffer refused a sample");
endmodule

bind black_loop_and_gain_offset black_loop_and_gain_offset_properties i_black_loop_and_gain_offset_properties (
    .clk, .srst, .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_rdata, .cal_request, .cal_busy,
    .measured_offset_first, .measured_offset_second, .measured_offset_third, .sample_valid, .sample_ready,
    .sample_raw, .sample_segment, .black_pixel, .black_level, .out_valid, .out_ready, .out_data);
`default_nettype wire

// *** converter_model.sv ***
// converter side model: queued samples offered with valid and ready
`timescale 1ns/1ps
`default_nettype none
module converter_model
    import front_end_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               sample_ready,
    output logic                    sample_valid = 1'b0,
    output logic [9:0]              sample_raw = 10'h000,
    output front_end_pkg::segment_t sample_segment = SEG_8X,
    output logic                    black_pixel = 1'b0
);
    logic [12:0] pending[$];
    logic [12:0] word;

    // queue one sample: black flag, segment, raw code
    task automatic send(input logic blk, input segment_t seg, input logic [9:0] raw);
        pending.push_back({blk, seg, raw});
    endtask

    // hold a word until taken; idle raw code toggles
    always @(posedge clk) begin
        if (srst) begin
            sample_valid <= 1'b0;
        end else if (!sample_valid || sample_ready) begin
            if (pending.size() > 0) begin
                word = pending.pop_front();
                sample_valid   <= 1'b1;
                black_pixel    <= word[12];
                sample_segment <= segment_t'(word[11:10]);
                sample_raw     <= word[9:0];
            end else begin
                sample_valid <= 1'b0;
                sample_raw   <= ~sample_raw;
            end
        end
    end
endmodule
`default_nettype wire

// *** black_loop_and_gain_offset_tb.sv ***
// self-checking bench for the black loop and segment correction block
`timescale 1ns/1ps
`default_nettype none
module black_loop_and_gain_offset_tb;
    import front_end_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_write = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_read = 1'b0;
    logic [7:0]  reg_rdata;
    logic        cal_request = 1'b0;
    logic        cal_busy;
    logic [7:0]  measured_offset_first = 8'hFD;
    logic [7:0]  measured_offset_second = 8'h05;
    logic [7:0]  measured_offset_third = 8'h80;
    logic        sample_valid;
    logic        sample_ready;
    logic [9:0]  sample_raw;
    segment_t    sample_segment;
    logic        black_pixel;
    logic [8:0]  black_level;
    logic        out_valid;
    logic        out_ready = 1'b1;
    logic [12:0] out_data;
    logic [12:0] got[$];
    int          num_errors = 0;
    int          checks_done = 0;

    always #12.5 clk = ~clk;

    black_loop_and_gain_offset i_black_loop_and_gain_offset (.clk, .srst, .reg_addr, .reg_write,
        .reg_wdata, .reg_read, .reg_rdata, .cal_request, .cal_busy, .measured_offset_first,
        .measured_offset_second, .measured_offset_third, .sample_valid, .sample_ready, .sample_raw,
        .sample_segment, .black_pixel, .black_level, .out_valid, .out_ready, .out_data);
    converter_model i_converter_model (.clk, .srst, .sample_ready, .sample_valid, .sample_raw,
        .sample_segment, .black_pixel);

    // collect every word handed downstream
    always @(posedge clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back(out_data);
        end
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task automatic wait_out(input int n);
        int k;
        k = 0;
        while (got.size() < n && k < 300) begin
            @(posedge clk);
            k++;
        end
        #1;
        chk(got.size(), n);
    endtask

    // expected corrected word, clipped to the 13-bit range
    function automatic logic [12:0] corrected(input int s, input logic [9:0] raw);
        int v;
        int r;
        r = raw;
        case (s)
            3: v = r;
            2: v = 2 * r + int'($signed(measured_offset_first));
            1: v = 4 * r + 2 * int'($signed(measured_offset_second));
            default: v = 8 * r + 4 * int'($signed(measured_offset_third));
        endcase
        if (v < 0) v = 0;
        if (v > 8191) v = 8191;
        return v[12:0];
    endfunction

    task automatic t_reset_values;
        rd_chk(ADDR_BLACK_LOOP, 8'h2A);
        rd_chk(ADDR_CORR_FIRST, 8'h00);
        rd_chk(ADDR_CORR_SECOND, 8'h00);
        rd_chk(ADDR_CORR_THIRD, 8'h00);
        rd_chk(8'h11, 8'h00);
    endtask

    task automatic t_reg_access;
        wr(ADDR_BLACK_LOOP, 8'hC5);
        rd_chk(ADDR_BLACK_LOOP, 8'hC5);
        wr(ADDR_CORR_SECOND, 8'h5A);
        rd_chk(ADDR_CORR_SECOND, 8'h00);
        wr(8'h11, 8'hFF);
        rd_chk(8'h11, 8'h00);
    endtask

    // run with a second request mid-run, which must be ignored
    task automatic t_calibrate;
        int n;
        @(posedge clk);
        cal_request <= 1'b1;
        @(posedge clk);
        cal_request <= 1'b0;
        #1;
        n = 0;
        while (cal_busy === 1'b1 && n < 2000) begin
            @(posedge clk);
            cal_request <= (n == 99);
            #1;
            n++;
        end
        chk(n, 760);
        rd_chk(ADDR_CORR_FIRST, 8'hFD);
        rd_chk(ADDR_CORR_SECOND, 8'h05);
        rd_chk(ADDR_CORR_THIRD, 8'h80);
    endtask

    task automatic t_segments;
        logic [9:0] raws[3];
        raws = '{10'h00A, 10'h064, 10'h3FF};
        for (int s = 0; s < 4; s++) begin
            for (int r = 0; r < 3; r++) begin
                i_converter_model.send(1'b0, segment_t'(s[1:0]), raws[r]);
            end
        end
        wait_out(12);
        for (int i = 0; i < 12; i++) begin
            chk(got[i], corrected(i / 3, raws[i % 3]));
        end
        got.delete();
    endtask

    // stalled sink: two words held, third refused, order kept
    task automatic t_backpressure;
        @(posedge clk);
        out_ready <= 1'b0;
        for (int i = 1; i < 4; i++) begin
            i_converter_model.send(1'b0, SEG_8X, 10'(i));
        end
        repeat (6) @(posedge clk);
        #1;
        chk(sample_ready, 1'b0);
        chk(out_data, 13'h0001);
        chk(got.size(), 0);
        @(posedge clk);
        out_ready <= 1'b1;
        wait_out(3);
        for (int i = 0; i < 3; i++) begin
            chk(got[i], 16'(i + 1));
        end
        got.delete();
    endtask

    // four zero-code black pixels per update, each weight code
    task automatic t_black_loop;
        logic [8:0] lvl;
        lvl = 9'h100;
        for (int w = 0; w < 4; w++) begin
            wr(ADDR_BLACK_LOOP, {w[1:0], 6'h04});
            repeat (3) i_converter_model.send(1'b1, SEG_8X, 10'h000);
            wait_out(3);
            chk(black_level, lvl);
            i_converter_model.send(1'b1, SEG_8X, 10'h000);
            wait_out(4);
            lvl = lvl + (9'h001 << w);
            chk(black_level, lvl);
            got.delete();
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset_values();
        t_reg_access();
        t_calibrate();
        t_segments();
        t_backpressure();
        t_black_loop();
        results();
    end

    // tests need under 2000 cycles
    initial begin
        #(25 * 20000);
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
